// >>> src/scd_pkg.sv
// Purpose: constants and types for the command/address decode front end
// Assumes: command pins are captured on the link clock, bank state on clk_sys
// Notes:   field positions and command codes are named here only once
// Notes on behaviour
// - Activate takes all sixteen address bits as the row of the bank.
// - Read and write take the column from address bits 0 to 9 only.
// - Mode register set loads the address bits as an opcode.
// - Read/write address bit 10 high closes the bank after access.
// - Precharge bit 10 low closes one bank, high closes all banks.
// - Read/write address bit 12 low chops the burst, high runs full.
// - Chip select high masks every command on that edge.
// - Row, column and write strobes are latched on the link clock rise.
// - Activate code opens the bank named by the bank address.
// - Precharge code returns the named bank to idle.
// - Row strobe high, column strobe low: write enable picks read or write.
// - Data strobe is driven with read data, received on writes.
// - Termination strobe enabled disables the mask, gives termination only.
// - Bank address bits pick the bank a command applies to, except precharge all; mode register set uses them to pick the register.
// - Mask high during a write discards that byte if termination is off.
// - Termination strobe enables only from address bit 11 of mode register 1.
package scd_pkg;
    localparam int ADDR_W    = 16;
    localparam int BA_W      = 3;
    localparam int NBANK     = 8;
    localparam int COL_W     = 10;
    localparam int NMR       = 4;
    localparam int MR_SEL_W  = 2;
    localparam int SYNC_N    = 3;
    localparam int AP_BIT    = 10;
    localparam int TDQS_BIT  = 11;
    localparam int BC_BIT    = 12;
    localparam logic [MR_SEL_W-1:0] MR_TERM = 2'h1;
    // Strobe codes as {row, column, write}, all active low
    localparam logic [2:0] RCW_MRS = 3'h0;
    localparam logic [2:0] RCW_PRE = 3'h2;
    localparam logic [2:0] RCW_ACT = 3'h3;
    localparam logic [2:0] RCW_WR  = 3'h4;
    localparam logic [2:0] RCW_RD  = 3'h5;
    localparam logic [2:0] RCW_NOP = 3'h7;

    typedef enum logic [6:0] {
        CMD_NONE  = 7'h01,
        CMD_ACT   = 7'h02,
        CMD_PRE   = 7'h04,
        CMD_READ  = 7'h08,
        CMD_WRITE = 7'h10,
        CMD_MRS   = 7'h20,
        CMD_OTHER = 7'h40
    } scd_cmd_t;

    typedef struct packed {
        logic              cs_n;
        logic [2:0]        rcw;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] a;
    } scd_word_t;
endpackage : scd_pkg

// >>> src/scd_decode.sv
// Purpose: command and address decoding front end of a synchronous DRAM
// Assumes: clk_sys runs at least four times faster than ck_link
// Notes:   link side captures pins, system side keeps bank and mode state
`timescale 1ns/1ps
`default_nettype none
module scd_decode
    import scd_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ck_link,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [BA_W-1:0]   ba,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              dm,
    input  wire logic              dqs_i,
    output logic                   dqs_o,
    output logic                   dqs_oe_n,
    output logic                   wr_byte_drop,
    output logic                   tdqs_term_en,
    input  wire logic              rd_drive,
    output logic                   cmd_valid,
    output scd_cmd_t               cmd_kind,
    output logic [BA_W-1:0]        cmd_bank,
    output logic [ADDR_W-1:0]      cmd_row,
    output logic [COL_W-1:0]       cmd_col,
    output logic [ADDR_W-1:0]      cmd_opcode,
    output logic                   cmd_auto_pre,
    output logic                   cmd_chop,
    output logic                   cmd_pre_all,
    output logic                   cmd_err,
    output logic [NBANK-1:0]       bank_open,
    output logic                   tdqs_en
);

    // ==========================================================
    // Decode
    function automatic scd_cmd_t decode(input scd_word_t w);
        if (w.cs_n) begin
            return CMD_NONE;
        end
        case (w.rcw)
            RCW_ACT: return CMD_ACT;
            RCW_PRE: return CMD_PRE;
            RCW_RD:  return CMD_READ;
            RCW_WR:  return CMD_WRITE;
            RCW_MRS: return CMD_MRS;
            RCW_NOP: return CMD_NONE;
            default: return CMD_OTHER;
        endcase
    endfunction : decode

    // ==========================================================
    // Link domain state
    typedef struct packed {
        logic [1:0]  rsync;
        scd_word_t   word;
        logic        tog;
        logic [1:0]  rdsync;
        logic [1:0]  tdsync;
        logic        dqs;
        logic        drive;
        logic        drop;
    } scd_link_t;

    // ==========================================================
    // System domain state
    typedef struct packed {
        logic [SYNC_N-1:0]                 tsync;
        logic                              tprev;
        logic [NBANK-1:0]                  open;
        logic [NBANK-1:0][ADDR_W-1:0]      rows;
        logic [NMR-1:0][ADDR_W-1:0]        mr;
        logic                              valid;
        scd_cmd_t                          kind;
        logic [BA_W-1:0]                   bank;
        logic [ADDR_W-1:0]                 row;
        logic [COL_W-1:0]                  col;
        logic [ADDR_W-1:0]                 op;
        logic                              ap;
        logic                              chop;
        logic                              all;
        logic                              err;
    } scd_sys_t;

    scd_link_t l;
    scd_link_t next_l;
    scd_sys_t  s;
    scd_sys_t  next_s;
    logic      link_rst;
    logic      evt;
    scd_cmd_t  dk;

    assign link_rst = ~l.rsync[1];

    // ==========================================================
    // Link logic: pins sampled on the rising link clock
    always_comb begin
        next_l       = l;
        next_l.rsync = {l.rsync[0], rst_n};
        next_l.rdsync = {l.rdsync[0], rd_drive};
        next_l.tdsync = {l.tdsync[0], s.mr[MR_TERM][TDQS_BIT]};
        // Deselected edges never reach the system side
        if (!cs_n) begin
            next_l.word.cs_n = cs_n;
            next_l.word.rcw  = {ras_n, cas_n, we_n};
            next_l.word.ba   = ba;
            next_l.word.a    = addr;
            next_l.tog       = ~l.tog;
        end
        next_l.drive = l.rdsync[1];
        // Strobe toggles with each read beat, idles low otherwise
        next_l.dqs   = l.rdsync[1] ? ~l.dqs : 1'b0;
        // Mask is honoured only while the strobe is received
        next_l.drop  = ~l.drive & dm & ~l.tdsync[1];
        if (link_rst) begin
            next_l       = '0;
            // Keep shifting the reset in, or the link would never leave reset
            next_l.rsync = {l.rsync[0], rst_n};
            next_l.word.cs_n = 1'b1;
            next_l.word.rcw  = RCW_NOP;
        end
    end

    always_ff @(posedge ck_link) begin
        l <= next_l;
    end

    assign dqs_o        = l.dqs;
    assign dqs_oe_n     = ~l.drive;
    assign wr_byte_drop = l.drop;
    assign tdqs_term_en = l.tdsync[1];

    // ==========================================================
    // System logic: the word is stable long before the next link edge
    assign evt = s.tsync[SYNC_N-1] ^ s.tprev;
    assign dk  = decode(l.word);

    always_comb begin
        next_s       = s;
        next_s.tsync = {s.tsync[SYNC_N-2:0], l.tog};
        next_s.tprev = s.tsync[SYNC_N-1];
        next_s.valid = 1'b0;
        if (evt && dk != CMD_NONE) begin
            next_s.valid = 1'b1;
            next_s.kind  = dk;
            next_s.bank  = l.word.ba;
            next_s.err   = 1'b0;
            next_s.all   = 1'b0;
            case (dk)
                CMD_ACT: begin
                    next_s.open[l.word.ba] = 1'b1;
                    next_s.rows[l.word.ba] = l.word.a;
                    next_s.row             = l.word.a;
                end
                CMD_PRE: begin
                    if (l.word.a[AP_BIT]) begin
                        next_s.open = '0;
                        next_s.all  = 1'b1;
                    end else begin
                        next_s.open[l.word.ba] = 1'b0;
                    end
                end
                CMD_READ, CMD_WRITE: begin
                    next_s.col  = l.word.a[COL_W-1:0];
                    next_s.row  = s.rows[l.word.ba];
                    next_s.ap   = l.word.a[AP_BIT];
                    next_s.chop = ~l.word.a[BC_BIT];
                    // Access to an idle bank is flagged with the error bit and still passed on as a valid command
                    next_s.err  = ~s.open[l.word.ba];
                    if (l.word.a[AP_BIT]) begin
                        next_s.open[l.word.ba] = 1'b0;
                    end
                end
                CMD_MRS: begin
                    next_s.mr[l.word.ba[MR_SEL_W-1:0]] = l.word.a;
                    next_s.op = l.word.a;
                end
                default: begin
                end
            endcase
        end
        if (!rst_n) begin
            next_s      = '0;
            next_s.kind = CMD_NONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        s <= next_s;
    end

    assign cmd_valid    = s.valid;
    assign cmd_kind     = s.kind;
    assign cmd_bank     = s.bank;
    assign cmd_row      = s.row;
    assign cmd_col      = s.col;
    assign cmd_opcode   = s.op;
    assign cmd_auto_pre = s.ap;
    assign cmd_chop     = s.chop;
    assign cmd_pre_all  = s.all;
    assign cmd_err      = s.err;
    assign bank_open    = s.open;
    assign tdqs_en      = s.mr[MR_TERM][TDQS_BIT];

    // ==========================================================
    // Checks
    property p_act_open;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_ACT |=> bank_open[cmd_bank] && cmd_row == $past(l.word.a);
    endproperty
    a_act_open: assert property (p_act_open) else $error("activate did not open bank");

    property p_col;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && (dk == CMD_READ || dk == CMD_WRITE) |=> cmd_col == $past(l.word.a[COL_W-1:0]);
    endproperty
    a_col: assert property (p_col) else $error("column address wrong");

    property p_ap;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_READ && l.word.a[AP_BIT] |=> cmd_auto_pre && !bank_open[cmd_bank];
    endproperty
    a_ap: assert property (p_ap) else $error("auto precharge not applied");

    property p_pre_all;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_PRE && l.word.a[AP_BIT] |=> bank_open == '0 && cmd_pre_all;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

    property p_pre_one;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_PRE && !l.word.a[AP_BIT] |=> !bank_open[cmd_bank] && !cmd_pre_all;
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("single precharge wrong");

    property p_chop;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_WRITE |=> cmd_chop == !$past(l.word.a[BC_BIT]) && cmd_kind == CMD_WRITE;
    endproperty
    a_chop: assert property (p_chop) else $error("burst chop wrong");

    property p_mrs;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_MRS && l.word.ba[MR_SEL_W-1:0] == MR_TERM
            |=> tdqs_en == $past(l.word.a[TDQS_BIT]) && cmd_opcode == $past(l.word.a);
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode register load wrong");

    property p_nop;
        @(posedge clk_sys) disable iff (!rst_n)
        !(evt && dk != CMD_NONE) |=> !cmd_valid && $stable(bank_open);
    endproperty
    a_nop: assert property (p_nop) else $error("bank state changed without command");

    property p_bank;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk != CMD_NONE |=> cmd_valid && cmd_bank == $past(l.word.ba);
    endproperty
    a_bank: assert property (p_bank) else $error("command bank wrong");

    property p_kind;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk != CMD_NONE |=> cmd_kind == $past(dk);
    endproperty
    a_kind: assert property (p_kind) else $error("command kind wrong");

    property p_pulse;
        @(posedge clk_sys) disable iff (!rst_n)
        cmd_valid |=> !cmd_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("command pulse too long");

    property p_ap_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_WRITE && l.word.a[AP_BIT] |=> cmd_auto_pre && !bank_open[cmd_bank];
    endproperty
    a_ap_wr: assert property (p_ap_wr) else $error("write auto precharge not applied");

    property p_no_ap;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && (dk == CMD_READ || dk == CMD_WRITE) && !l.word.a[AP_BIT] |=> !cmd_auto_pre;
    endproperty
    a_no_ap: assert property (p_no_ap) else $error("auto precharge without request");

    property p_chop_rd;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_READ |=> cmd_chop == !$past(l.word.a[BC_BIT]);
    endproperty
    a_chop_rd: assert property (p_chop_rd) else $error("read burst chop wrong");

    property p_err;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && (dk == CMD_READ || dk == CMD_WRITE) && !bank_open[l.word.ba] |=> cmd_err && $stable(bank_open);
    endproperty
    a_err: assert property (p_err) else $error("idle bank access not flagged");

    property p_no_err;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && (dk == CMD_READ || dk == CMD_WRITE) && bank_open[l.word.ba] |=> !cmd_err;
    endproperty
    a_no_err: assert property (p_no_err) else $error("open bank access flagged");

    property p_mrs_op;
        @(posedge clk_sys) disable iff (!rst_n)
        evt && dk == CMD_MRS |=> cmd_opcode == $past(l.word.a) && $stable(bank_open);
    endproperty
    a_mrs_op: assert property (p_mrs_op) else $error("opcode not loaded");

    // Link checks also wait for the system reset, which covers the unknown start
    property p_cs;
        @(posedge ck_link) disable iff (!rst_n || link_rst)
        cs_n |=> $stable(l.tog);
    endproperty
    a_cs: assert property (p_cs) else $error("deselected edge was taken");

    property p_cs_word;
        @(posedge ck_link) disable iff (!rst_n || link_rst)
        cs_n |=> $stable(l.word);
    endproperty
    a_cs_word: assert property (p_cs_word) else $error("deselected edge changed the word");

    property p_mask;
        @(posedge ck_link) disable iff (!rst_n || link_rst)
        l.tdsync[1] |=> !wr_byte_drop;
    endproperty
    a_mask: assert property (p_mask) else $error("mask active with termination strobe");

    property p_drop;
        @(posedge ck_link) disable iff (!rst_n || link_rst)
        dm && !l.drive && !l.tdsync[1] |=> wr_byte_drop;
    endproperty
    a_drop: assert property (p_drop) else $error("masked byte not dropped");

    property p_dqs;
        @(posedge ck_link) disable iff (!rst_n || link_rst)
        l.rdsync[1] |=> !dqs_oe_n && dqs_o != $past(dqs_o);
    endproperty
    a_dqs: assert property (p_dqs) else $error("strobe not driven on read");

    property p_dqs_idle;
        @(posedge ck_link) disable iff (!rst_n || link_rst)
        !l.rdsync[1] |=> dqs_oe_n && !dqs_o;
    endproperty
    a_dqs_idle: assert property (p_dqs_idle) else $error("strobe driven without read");

endmodule : scd_decode
`default_nettype wire

// >>> dv/scd_ctrl_model.sv
// Purpose: memory controller model driving the command pins on the link clock
// Assumes: pins change on the falling link edge and are sampled on the rising one
// Notes:   on release chip select goes high and the other pins show the inverse of their last value, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module scd_ctrl_model
    import scd_pkg::*;
(
    input  wire logic              ck_link,
    output logic                   cs_n,
    output logic                   ras_n,
    output logic                   cas_n,
    output logic                   we_n,
    output logic [BA_W-1:0]        ba,
    output logic [ADDR_W-1:0]      addr,
    output logic                   dqs_c
);
    initial begin
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = RCW_NOP;
        ba = '0;
        addr = '0;
        dqs_c = 1'b0;
    end
    // Write strobe reference; it keeps toggling when released so no level lingers
    always @(negedge ck_link) dqs_c <= ~dqs_c;
    // Only the idle-bank error scenario asks for an access outside an open bank
    task automatic issue(input logic cs, input logic [2:0] rcw, input logic [BA_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        @(negedge ck_link);
        cs_n = cs;
        {ras_n, cas_n, we_n} = rcw;
        ba = b;
        addr = a;
        @(negedge ck_link);
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = ~rcw;
        ba = ~b;
        addr = ~a;
    endtask : issue
endmodule : scd_ctrl_model
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: self-checking bench for the command and address decode front end
// Assumes: link clock free running at 48 ns, system clock at 5 ns
// Notes:   reset is held long enough for both clock domains to see it
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scd_pkg::*;
    typedef struct packed {
        logic              cs;
        logic [2:0]        rcw;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] a;
        logic              v;
        scd_cmd_t          kind;
        logic              err;
        logic [NBANK-1:0]  open;
        logic              tq;
    } scd_row_t;
    logic clk_sys = 1'b0, ck_link = 1'b0, rst_n = 1'b0, dm = 1'b0, rd_drive = 1'b0;
    logic cs_n, ras_n, cas_n, we_n, dqs_c, dqs_o, dqs_oe_n, dqs_wire, wr_byte_drop, tdqs_term_en;
    logic cmd_valid, cmd_auto_pre, cmd_chop, cmd_pre_all, cmd_err, tdqs_en, v;
    logic [BA_W-1:0] ba, cmd_bank;
    logic [ADDR_W-1:0] addr, cmd_row, cmd_opcode;
    logic [ADDR_W-1:0] open_row [NBANK];
    logic [COL_W-1:0] cmd_col;
    logic [NBANK-1:0] bank_open;
    scd_cmd_t cmd_kind;
    int error_cnt = 0, checks_done = 0;
    // Rows: select, strobes, bank, address, pulse, kind, error, open banks, termination
    scd_row_t rows [14] = '{
        '{1'b0, RCW_ACT, 3'h2, 16'ha5c3, 1'b1, CMD_ACT,   1'b0, 8'h04, 1'b0},
        '{1'b0, RCW_ACT, 3'h5, 16'hffff, 1'b1, CMD_ACT,   1'b0, 8'h24, 1'b0},
        '{1'b0, RCW_RD,  3'h2, 16'hf3ff, 1'b1, CMD_READ,  1'b0, 8'h24, 1'b0},
        '{1'b0, RCW_WR,  3'h5, 16'h0455, 1'b1, CMD_WRITE, 1'b0, 8'h04, 1'b0},
        '{1'b0, RCW_RD,  3'h5, 16'h0000, 1'b1, CMD_READ,  1'b1, 8'h04, 1'b0},
        '{1'b1, RCW_ACT, 3'h7, 16'h1234, 1'b0, CMD_ACT,   1'b0, 8'h04, 1'b0},
        '{1'b0, RCW_NOP, 3'h3, 16'h0000, 1'b0, CMD_NONE,  1'b0, 8'h04, 1'b0},
        '{1'b0, 3'h1,    3'h0, 16'h0000, 1'b1, CMD_OTHER, 1'b0, 8'h04, 1'b0},
        '{1'b0, RCW_PRE, 3'h2, 16'h0000, 1'b1, CMD_PRE,   1'b0, 8'h00, 1'b0},
        '{1'b0, RCW_ACT, 3'h0, 16'h0001, 1'b1, CMD_ACT,   1'b0, 8'h01, 1'b0},
        '{1'b0, RCW_ACT, 3'h3, 16'h8000, 1'b1, CMD_ACT,   1'b0, 8'h09, 1'b0},
        '{1'b0, RCW_PRE, 3'h1, 16'h0400, 1'b1, CMD_PRE,   1'b0, 8'h00, 1'b0},
        '{1'b0, RCW_MRS, 3'h0, 16'h0800, 1'b1, CMD_MRS,   1'b0, 8'h00, 1'b0},
        '{1'b0, RCW_MRS, 3'h1, 16'h0800, 1'b1, CMD_MRS,   1'b0, 8'h00, 1'b1}};
    always #2.5 clk_sys = ~clk_sys;
    initial begin
        #7.3;
        forever #24 ck_link = ~ck_link;
    end
    assign dqs_wire = dqs_oe_n ? dqs_c : dqs_o;
    scd_ctrl_model ctl (.ck_link(ck_link), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
                        .ba(ba), .addr(addr), .dqs_c(dqs_c));
    scd_decode dut (.clk_sys(clk_sys), .rst_n(rst_n), .ck_link(ck_link), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm), .dqs_i(dqs_wire), .dqs_o(dqs_o),
        .dqs_oe_n(dqs_oe_n), .wr_byte_drop(wr_byte_drop), .tdqs_term_en(tdqs_term_en),
        .rd_drive(rd_drive), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
        .cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_opcode(cmd_opcode), .cmd_auto_pre(cmd_auto_pre),
        .cmd_chop(cmd_chop), .cmd_pre_all(cmd_pre_all), .cmd_err(cmd_err), .bank_open(bank_open),
        .tdqs_en(tdqs_en));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    // The watcher runs beside the issue, since the pulse can land before the pins are released
    task automatic run_row(input scd_row_t r);
        logic got;
        got = 1'b0;
        fork
            ctl.issue(r.cs, r.rcw, r.ba, r.a);
            for (int i = 0; i < 60 && !got; i++) begin
                @(negedge clk_sys);
                if (cmd_valid === 1'b1) begin
                    got = 1'b1;
                    chk(cmd_kind, r.kind);
                    chk(cmd_bank, r.ba);
                    chk(cmd_err, r.err);
                    if (r.rcw == RCW_ACT) chk(cmd_row, r.a);
                    if (r.rcw == RCW_PRE) chk(cmd_pre_all, r.a[AP_BIT]);
                    if (r.rcw == RCW_MRS) chk(cmd_opcode, r.a);
                    if (r.rcw == RCW_RD || r.rcw == RCW_WR) begin
                        chk(cmd_col, r.a[COL_W-1:0]);
                        chk(cmd_auto_pre, r.a[AP_BIT]);
                        chk(cmd_chop, !r.a[BC_BIT]);
                        if (!r.err) chk(cmd_row, open_row[r.ba]);
                    end
                end
            end
        join
        if (r.v && r.rcw == RCW_ACT) open_row[r.ba] = r.a;
        chk(got, r.v);
        repeat (4) @(negedge clk_sys);
        chk(bank_open, r.open);
        chk(tdqs_en, r.tq);
    endtask : run_row
    initial begin
        #100_000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (30) @(negedge clk_sys);
        chk(cmd_valid, 1'b0);
        chk(cmd_kind, CMD_NONE);
        chk(bank_open, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge ck_link);
        foreach (rows[i]) run_row(rows[i]);
        // Termination on: the mask is ignored
        @(negedge ck_link) dm = 1'b1;
        repeat (4) @(negedge ck_link);
        chk(tdqs_term_en, 1'b1);
        chk(wr_byte_drop, 1'b0);
        run_row('{1'b0, RCW_MRS, 3'h1, 16'h0000, 1'b1, CMD_MRS, 1'b0, 8'h00, 1'b0});
        repeat (4) @(negedge ck_link);
        chk(tdqs_term_en, 1'b0);
        chk(wr_byte_drop, 1'b1);
        @(negedge ck_link) dm = 1'b0;
        repeat (2) @(negedge ck_link);
        chk(wr_byte_drop, 1'b0);
        // Read strobe: driven and toggling while read data goes out
        @(negedge clk_sys) rd_drive = 1'b1;
        @(negedge ck_link) dm = 1'b1;
        repeat (5) @(negedge ck_link);
        chk(dqs_oe_n, 1'b0);
        chk(wr_byte_drop, 1'b0);
        v = dqs_wire;
        @(negedge ck_link);
        chk(dqs_wire, !v);
        @(negedge clk_sys) rd_drive = 1'b0;
        @(negedge ck_link) dm = 1'b0;
        repeat (6) @(negedge ck_link);
        chk(dqs_oe_n, 1'b1);
        // Reset in mid-run closes every bank
        run_row('{1'b0, RCW_ACT, 3'h6, 16'h00f0, 1'b1, CMD_ACT, 1'b0, 8'h40, 1'b0});
        @(negedge clk_sys) rst_n = 1'b0;
        repeat (30) @(negedge clk_sys);
        chk(bank_open, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge ck_link);
        run_row('{1'b0, RCW_ACT, 3'h4, 16'h0f0f, 1'b1, CMD_ACT, 1'b0, 8'h10, 1'b0});
        close_out();
    end
endmodule : testbench
`default_nettype wire
